/* design/led_plane_ctrl.sv */
// Panel brightness, digit scaling and display plane control behind the serial port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Panel brightness from 8-bit duty register 0x02.
// - Panel duty spans 2/256 up to 255/256.
// - Digit on-time is n/256 of panel duty.
// - Combined duty never above 254/256.
// - Two digit scales, panel still governs all.
// - Depth bit picks four or two planes.
// - Reduced variant: depth bit reads zero, unwritable.
// - Two-bit levels arithmetic or geometric graduation.
// - Graduation choice held per digit.
// - Eight-bit driver select pointer register.
// - Fourteen-bit pointer at 0x09 and 0x0A.
// - Pointer increments per byte, wraps at 0x3FFF.
// - Manual mode: low bits pick displayed plane.
// - Slow auto mode: advance every n seconds.
// - Fast auto mode: advance n times per second.
// - New plane at frame end (code switches at once, on the register write or on plane_tick); auto starts at zero.
module led_plane_ctrl #(
  parameter int SECOND_CYCLES = led_plane_pkg::SECOND_CYCLES_DEF, // Cycles in one second.
  parameter bit FOUR_LEVEL = 1'b1 // Zero builds the reduced variant.
) (
  input wire logic clk, // System clock, 50 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic sclk, // Serial clock from the host.
  input wire logic cs_n, // Serial chip select, active low.
  input wire logic din, // Serial data in.
  output logic dout, // Serial read data out.
  input wire logic [3:0] pixel_level, // Pixel levels, digit 1 in bits 3:2.
  output logic [1:0] digit_drive, // Digit PWM windows.
  output logic [1:0] pixel_lit, // Digit drive gated by pixel level.
  output led_plane_pkg::mem_wr_t mem_wr, // Display memory write strobe.
  output logic [1:0] displayed_plane, // Plane now shown.
  output logic [7:0] driver_select, // Driver select pointer.
  output logic plane_depth_select // Two-plane mode when high.
);
  import led_plane_pkg::*;

  // ----------------------------------------------------------------------
  // Types and helpers
  // ----------------------------------------------------------------------
  typedef struct packed {
    regs_t regs; // Register file.
    logic cs_meta; // First synchroniser stage of chip select.
    logic cs_sync; // Second synchroniser stage.
    logic cs_prev; // Previous synchronised chip select.
    logic [4:0] base_cnt; // Link edge count at the last frame end.
    logic [15:0] read_word; // Word returned on the next frame.
    mem_wr_t mem; // Pending memory write.
    logic [1:0] plane; // Displayed plane.
    logic [4:0] step_div; // Cycles within one PWM step.
    logic [7:0] step; // PWM step within the digit period.
    logic digit_sel; // Digit being multiplexed.
    logic [3:0] mod_frame; // Mux cycle within the modulation pattern.
    logic [25:0] sec_cnt; // Cycles within the current second.
    logic [5:0] sec_num; // Seconds since the last slow advance.
    logic [25:0] fast_acc; // Rate accumulator for fast mode.
    logic [1:0] drive; // Registered digit windows.
    logic [1:0] lit; // Registered pixel outputs.
  } core_t;

  typedef struct packed {
    logic [4:0] cnt; // Free-running edge count, never cleared by frames.
    logic [15:0] shift; // Last sixteen bits received.
    logic dout; // Serial output bit.
  } link_t;

  // Scales the panel duty by a digit code; panel codes 1 and 2 give the minimum.
  function automatic logic [7:0] digit_duty(input logic [7:0] panel, input logic [7:0] n);
    logic [7:0] eff;
    logic [15:0] prod;
    eff = (panel != RST_BYTE && panel < PANEL_MIN_DUTY) ? PANEL_MIN_DUTY : panel;
    prod = eff * n;
    return prod[15:8];
  endfunction

  // Frame modulation of a two-bit level over twelve mux cycles.
  function automatic logic pixel_on(input logic [1:0] level, input logic arith, input logic [3:0] f);
    logic [3:0] m3;
    m3 = f % 4'h3;
    case (level)
      2'b11: pixel_on = 1'b1;
      2'b10: pixel_on = arith ? (m3 != 4'h1) : (f[0] == 1'b0);
      2'b01: pixel_on = arith ? (m3 == 4'h1) : (f[1:0] == 2'b01);
      default: pixel_on = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------------
  logic rst_meta; // First reset stage.
  logic rst_s; // Synchronised reset, active low.

  // Releases reset two clock edges after rst_n rises.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_s <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_s <= rst_meta;
    end
  end

  core_t st; // Core state.
  core_t next_st; // Next core state.
  link_t lk; // Link state.
  link_t next_lk; // Next link state.

  // ----------------------------------------------------------------------
  // Link domain
  // ----------------------------------------------------------------------
  // Shifts in on each rising sclk inside a frame and shifts out the read word.
  // The core reads the count and shift only while chip select is high and sclk
  // stands still, and the link reads read_word and base_cnt only inside a
  // frame, when the core leaves them untouched.
  always_comb begin
    logic [4:0] idx;
    idx = 5'h00;
    next_lk = lk;
    if (!cs_n) begin
      idx = lk.cnt - st.base_cnt;
      next_lk.shift = {lk.shift[14:0], din};
      next_lk.cnt = lk.cnt + 5'h01;
      next_lk.dout = st.read_word[4'hF - idx[3:0]];
    end
  end

  // Registers the link state.
  always_ff @(posedge sclk or negedge rst_s) begin
    if (!rst_s) begin
      lk <= '0;
    end else begin
      lk <= next_lk;
    end
  end

  // ----------------------------------------------------------------------
  // Core domain
  // ----------------------------------------------------------------------
  logic frame_end; // Synchronised rising edge of chip select.
  logic [4:0] frame_len; // Bits in the frame just ended.
  logic [7:0] duty0; // Digit 0 duty.
  logic [7:0] duty1; // Digit 1 duty.
  logic plane_tick; // Automatic plane advance.
  logic [26:0] fast_sum; // Accumulator plus rate.

  assign frame_end = st.cs_sync & ~st.cs_prev;
  assign frame_len = lk.cnt - st.base_cnt;
  assign duty0 = digit_duty(st.regs.panel, st.regs.digit0);
  assign duty1 = digit_duty(st.regs.panel, st.regs.digit1);
  assign fast_sum = {1'b0, st.fast_acc} + {21'h000000, st.regs.seq[5:0]};

  // Decodes frames, runs the plane sequencer and the digit PWM.
  always_comb begin
    logic [15:0] word;
    logic [7:0] rd;
    logic [1:0] lvl;
    word = lk.shift;
    rd = RST_BYTE;
    lvl = 2'b00;
    plane_tick = 1'b0;
    next_st = st;
    next_st.cs_meta = cs_n;
    next_st.cs_sync = st.cs_meta;
    next_st.cs_prev = st.cs_sync;
    next_st.mem.valid = 1'b0;
    if (!FOUR_LEVEL) begin
      next_st.regs.depth = 1'b0;
    end
    // Plane rate timing; a zero setting holds the sequencer.
    if (st.regs.seq[SEQ_AUTO_BIT] && st.regs.seq[5:0] != 6'h00) begin
      if (st.regs.seq[SEQ_FAST_BIT]) begin
        if (fast_sum >= 27'(SECOND_CYCLES)) begin
          next_st.fast_acc = 26'(fast_sum - 27'(SECOND_CYCLES));
          plane_tick = 1'b1;
        end else begin
          next_st.fast_acc = fast_sum[25:0];
        end
      end else if (st.sec_cnt == 26'(SECOND_CYCLES - 1)) begin
        next_st.sec_cnt = 26'h0000000;
        if (st.sec_num + 6'h01 >= st.regs.seq[5:0]) begin
          next_st.sec_num = 6'h00;
          plane_tick = 1'b1;
        end else begin
          next_st.sec_num = st.sec_num + 6'h01;
        end
      end else begin
        next_st.sec_cnt = st.sec_cnt + 26'h0000001;
      end
    end
    if (plane_tick) begin
      next_st.plane = st.regs.depth ? {1'b0, ~st.plane[0]} : st.plane + 2'b01;
    end
    // Frame decode at the end of each transfer.
    if (frame_end) begin
      next_st.base_cnt = lk.cnt;
      if (frame_len == FRAME_SHORT) begin
        next_st.mem.valid = 1'b1;
        next_st.mem.addr = st.regs.ptr;
        next_st.mem.data = word[7:0];
        next_st.regs.ptr = st.regs.ptr + 14'h0001;
      end else if (frame_len == FRAME_LONG && word[FRAME_READ_BIT]) begin
        if (word[14:8] == ADDR_PANEL) begin
          rd = st.regs.panel;
        end else if (word[14:8] == ADDR_DIGIT0) begin
          rd = st.regs.digit0;
        end else if (word[14:8] == ADDR_DIGIT1) begin
          rd = st.regs.digit1;
        end else if (word[14:8] == ADDR_GRAD) begin
          rd = {6'h00, st.regs.grad};
        end else if (word[14:8] == ADDR_DRIVER) begin
          rd = st.regs.driver;
        end else if (word[14:8] == ADDR_PTR_LO) begin
          rd = st.regs.ptr[7:0];
        end else if (word[14:8] == ADDR_PTR_HI) begin
          rd = {2'b00, st.regs.ptr[13:8]};
        end else if (word[14:8] == ADDR_PLANE) begin
          rd = st.regs.seq;
        end else if (word[14:8] == ADDR_CONFIG) begin
          rd = (8'(st.regs.depth) << CFG_DEPTH_BIT) | (8'(st.plane) << CFG_PLANE_LSB);
        end else begin
          rd = RST_BYTE; // Unmapped codes read as zero.
        end
        next_st.read_word = {word[15:8], rd};
      end else if (frame_len == FRAME_LONG) begin
        if (word[14:8] == ADDR_PANEL) begin
          next_st.regs.panel = word[7:0];
        end else if (word[14:8] == ADDR_DIGIT0) begin
          next_st.regs.digit0 = word[7:0];
        end else if (word[14:8] == ADDR_DIGIT1) begin
          next_st.regs.digit1 = word[7:0];
        end else if (word[14:8] == ADDR_GRAD) begin
          next_st.regs.grad = word[1:0];
        end else if (word[14:8] == ADDR_DRIVER) begin
          next_st.regs.driver = word[7:0];
        end else if (word[14:8] == ADDR_PTR_LO) begin
          next_st.regs.ptr[7:0] = word[7:0];
        end else if (word[14:8] == ADDR_PTR_HI) begin
          next_st.regs.ptr[13:8] = word[5:0];
        end else if (word[14:8] == ADDR_PLANE) begin
          next_st.regs.seq = word[7:0];
          next_st.sec_cnt = 26'h0000000;
          next_st.sec_num = 6'h00;
          next_st.fast_acc = 26'h0000000;
          if (word[SEQ_AUTO_BIT]) begin
            next_st.plane = 2'b00;
          end else begin
            next_st.plane = st.regs.depth ? {1'b0, word[0]} : word[1:0];
          end
        end else if (word[14:8] == ADDR_CONFIG) begin
          next_st.regs.depth = FOUR_LEVEL ? word[CFG_DEPTH_BIT] : 1'b0;
        end
      end
    end
    // Digit multiplex and PWM step timing.
    if (st.step_div == STEP_LAST) begin
      next_st.step_div = 5'h00;
      next_st.step = st.step + 8'h01;
      if (st.step == 8'hFF) begin
        next_st.digit_sel = ~st.digit_sel;
        if (st.digit_sel) begin
          next_st.mod_frame = (st.mod_frame == MOD_LAST) ? 4'h0 : st.mod_frame + 4'h1;
        end
      end
    end else begin
      next_st.step_div = st.step_div + 5'h01;
    end
    // Each digit is lit only in its own period while the step is under its duty.
    next_st.drive[0] = ~st.digit_sel && (st.step < duty0);
    next_st.drive[1] = st.digit_sel && (st.step < duty1);
    for (int d = 0; d < 2; d++) begin
      lvl = pixel_level[2 * d +: 2];
      if (st.regs.depth) begin
        next_st.lit[d] = next_st.drive[d] && pixel_on(lvl, st.regs.grad[d], st.mod_frame);
      end else begin
        next_st.lit[d] = next_st.drive[d] && lvl[0];
      end
    end
  end

  // Registers the core state.
  always_ff @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
      st <= '0;
      st.cs_meta <= 1'b1;
      st.cs_sync <= 1'b1;
      st.cs_prev <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign dout = lk.dout;
  assign digit_drive = st.drive;
  assign pixel_lit = st.lit;
  assign mem_wr = st.mem;
  assign displayed_plane = st.plane;
  assign driver_select = st.regs.driver;
  assign plane_depth_select = st.regs.depth;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_s);

  sequence s_long_write(logic [6:0] a);
    frame_end && frame_len == FRAME_LONG && !lk.shift[FRAME_READ_BIT] && lk.shift[14:8] == a;
  endsequence

  property p_depth_locked;
    !FOUR_LEVEL |-> !st.regs.depth;
  endproperty
  a_depth_locked: assert property (p_depth_locked) else $error("depth bit set on reduced variant");

  property p_gap;
    (st.drive != 2'b00) |-> $past(st.step) < 8'hFE;
  endproperty
  a_gap: assert property (p_gap) else $error("digit lit in blanking gap");

  property p_one_digit;
    !(st.drive[0] && st.drive[1]);
  endproperty
  a_one_digit: assert property (p_one_digit) else $error("both digits driven");

  property p_off;
    (st.regs.panel == RST_BYTE) [*2] |-> st.drive == 2'b00;
  endproperty
  a_off: assert property (p_off) else $error("panel lit at zero brightness");

  property p_min_duty;
    (st.regs.panel == 8'h01 && st.regs.digit0 == 8'hFF) |-> duty0 == 8'h01;
  endproperty
  a_min_duty: assert property (p_min_duty) else $error("minimum duty scaling wrong");

  property p_ptr_inc;
    (frame_end && frame_len == FRAME_SHORT) |=> mem_wr.valid && mem_wr.addr == $past(st.regs.ptr)
      && st.regs.ptr == $past(st.regs.ptr) + 14'h0001;
  endproperty
  a_ptr_inc: assert property (p_ptr_inc) else $error("pointer did not advance");

  property p_manual;
    s_long_write(ADDR_PLANE) ##0 !lk.shift[SEQ_AUTO_BIT] ##0 !st.regs.depth
      |=> st.plane == $past(lk.shift[1:0]);
  endproperty
  a_manual: assert property (p_manual) else $error("manual plane not taken");

  property p_auto_start;
    s_long_write(ADDR_PLANE) ##0 lk.shift[SEQ_AUTO_BIT] |=> st.plane == 2'b00 && st.sec_num == 6'h00;
  endproperty
  a_auto_start: assert property (p_auto_start) else $error("auto sequence did not start at plane 0");

  property p_tick_steps;
    (plane_tick && !frame_end) |=> st.plane != $past(st.plane) && (!st.regs.depth || !st.plane[1]);
  endproperty
  a_tick_steps: assert property (p_tick_steps) else $error("plane did not advance on tick");

endmodule : led_plane_ctrl
`default_nettype wire

/* design/led_plane_pkg.sv */
// Shared constants and types for the panel intensity and plane control block.
package led_plane_pkg;
  // ----------------------------------------------------------------------
  // Register address codes
  // ----------------------------------------------------------------------
  localparam logic [6:0] ADDR_PANEL = 7'h02; // Panel brightness duty code.
  localparam logic [6:0] ADDR_DIGIT0 = 7'h03; // Digit 0 fractional intensity.
  localparam logic [6:0] ADDR_DIGIT1 = 7'h04; // Digit 1 fractional intensity.
  localparam logic [6:0] ADDR_GRAD = 7'h05; // Per-digit graduation choice.
  localparam logic [6:0] ADDR_DRIVER = 7'h08; // Driver select pointer.
  localparam logic [6:0] ADDR_PTR_LO = 7'h09; // Display pointer low byte.
  localparam logic [6:0] ADDR_PTR_HI = 7'h0A; // Display pointer high bits.
  localparam logic [6:0] ADDR_PLANE = 7'h0B; // Plane sequencer.
  localparam logic [6:0] ADDR_CONFIG = 7'h0D; // Panel configuration.
  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CFG_DEPTH_BIT = 7; // Plane depth select in the configuration.
  localparam int CFG_PLANE_LSB = 2; // Current plane, read only, bits 3:2.
  localparam int SEQ_FAST_BIT = 7; // Fast (per second) or slow (seconds) rate.
  localparam int SEQ_AUTO_BIT = 6; // Automatic sequencing enable.
  localparam int FRAME_READ_BIT = 15; // Read flag of a 16-bit frame.
  // ----------------------------------------------------------------------
  // Reset values and frame lengths
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00; // Every register clears to zero.
  localparam logic [4:0] FRAME_SHORT = 5'h08; // Display memory data frame.
  localparam logic [4:0] FRAME_LONG = 5'h10; // Register access frame.
  localparam logic [3:0] MOD_LAST = 4'hB; // Twelve mux cycles per pattern.
  localparam logic [7:0] PANEL_MIN_DUTY = 8'h02; // Lowest lit panel duty.
  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20; // System clock period.
  localparam int DIGIT_PERIOD_NS = 122000; // One digit multiplex period.
  localparam int PWM_STEPS = 256; // Steps per digit period.
  localparam int STEP_CYCLES = DIGIT_PERIOD_NS / (PWM_STEPS * CLK_PERIOD_NS); // Cycles per step.
  localparam logic [4:0] STEP_LAST = 5'(STEP_CYCLES - 1); // Last count of a step.
  localparam int SECOND_NS = 1000000000; // One second.
  localparam int SECOND_CYCLES_DEF = SECOND_NS / CLK_PERIOD_NS; // Cycles per second.
  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] panel; // Panel brightness code.
    logic [7:0] digit0; // Digit 0 scale.
    logic [7:0] digit1; // Digit 1 scale.
    logic [1:0] grad; // Bit d set selects arithmetic graduation for digit d.
    logic [7:0] driver; // Driver select pointer.
    logic [13:0] ptr; // Display memory pointer.
    logic [7:0] seq; // Plane sequencer setting.
    logic depth; // Two planes of two bits when set.
  } regs_t;
  typedef struct packed {
    logic valid; // One-cycle write strobe.
    logic [13:0] addr; // Display memory byte address.
    logic [7:0] data; // Byte to store.
  } mem_wr_t;
endpackage : led_plane_pkg

/* dv/led_host_model.sv */
// Behavioural host that drives the four-wire serial port of the block.
`timescale 1ns/1ps
`default_nettype none
module led_host_model (
  output logic sclk, // Serial clock, still between frames.
  output logic cs_n, // Chip select, active low.
  output logic din, // Serial data to the device.
  input wire logic dout // Serial data from the device.
);
  // ----------------------------------------------------------------------
  // Frame task
  // ----------------------------------------------------------------------
  // Sends nbits of word MSB first at a 125 ns bit time and gathers dout.
  task automatic xfer(input int nbits, input logic [15:0] word, output logic [15:0] rdata);
    int i;
    rdata = 16'h0000;
    cs_n = 1'b0;
    for (i = nbits - 1; i >= 0; i--) begin
      din = word[i];
      #62.5 sclk = 1'b1;
      #62.0 rdata = {rdata[14:0], dout};
      #0.5 sclk = 1'b0;
    end
    #62.5 cs_n = 1'b1;
    // A released data line must not keep showing the last bit.
    din = ~din;
    // Idle gap well above the required 100 ns between frames.
    #200.0;
  endtask
  // Idle levels from time zero.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end
endmodule // led_host_model
`default_nettype wire

/* dv/led_matrix_intensity_plane_ctrl_tb_top.sv */
// Self-checking bench for the panel intensity and plane control block.
`timescale 1ns/1ps
`default_nettype none
module led_matrix_intensity_plane_ctrl_tb_top;
  import led_plane_pkg::*;
  logic clk; // System clock.
  logic rst_n; // Reset, active low.
  logic sclk; // Serial clock.
  logic cs_n; // Serial select, active low.
  logic din; // Serial data in.
  logic dout; // Serial data out.
  logic [3:0] pixel_level; // Pixel levels.
  logic [1:0] digit_drive; // Digit windows.
  logic [1:0] pixel_lit; // Pixel outputs.
  logic lite_depth; // Depth bit of the reduced variant.
  mem_wr_t mem_wr; // Display memory write.
  logic [1:0] displayed_plane; // Plane shown.
  logic [7:0] driver_select; // Driver pointer.
  logic plane_depth_select; // Two-plane mode.
  int num_errors = 0; // Mismatch count.
  int samples_checked = 0; // Comparison count.
  int cycles = 0; // Run length in clock cycles.
  int wr_count = 0; // Memory write pulses seen.
  logic [13:0] wr_addr; // Last memory write address.
  logic [7:0] wr_data; // Last memory write byte.
  // ----------------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------------
  led_plane_ctrl #(.SECOND_CYCLES(64), .FOUR_LEVEL(1'b1)) dut_u (.clk(clk), .rst_n(rst_n), .sclk(sclk),
    .cs_n(cs_n), .din(din), .dout(dout), .pixel_level(pixel_level), .digit_drive(digit_drive),
    .pixel_lit(pixel_lit), .mem_wr(mem_wr), .displayed_plane(displayed_plane), .driver_select(driver_select),
    .plane_depth_select(plane_depth_select));
  led_plane_ctrl #(.SECOND_CYCLES(64), .FOUR_LEVEL(1'b0)) lite_u (.clk(clk), .rst_n(rst_n), .sclk(sclk),
    .cs_n(cs_n), .din(din), .dout(), .pixel_level(pixel_level), .digit_drive(), .pixel_lit(), .mem_wr(),
    .displayed_plane(), .driver_select(), .plane_depth_select(lite_depth));
  led_host_model host_u (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
  // Clock at 50 MHz.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Captures memory write pulses and cuts a hung run short.
  always @(posedge clk) begin
    cycles++;
    if (mem_wr.valid === 1'b1) begin
      wr_count++;
      wr_addr = mem_wr.addr;
      wr_data = mem_wr.data;
    end
    if (cycles == 95000) begin
      num_errors++;
      test_done();
    end
  end
  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  // Prints the verdict and ends the run.
  task automatic test_done();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Compares one value and reports a mismatch.
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Writes one register through a 16-bit frame.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] r;
    host_u.xfer(16, {1'b0, a, d}, r);
  endtask
  // Reads one register; the answer comes back in the following frame.
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    logic [15:0] r;
    host_u.xfer(16, {1'b1, a, 8'h00}, r);
    host_u.xfer(16, {1'b1, 7'h7F, 8'h00}, r);
    check("read_header", {8'h00, 1'b1, a}, {8'h00, r[15:8]});
    d = r[7:0];
  endtask
  // Measures the length of the next complete high window of one digit.
  task automatic measure(input int d, output int len);
    int n;
    len = 0;
    for (n = 0; n < 12000 && digit_drive[d] !== 1'b0; n++) begin
      @(posedge clk);
      #1;
    end
    for (n = 0; n < 12000 && digit_drive[d] !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    for (n = 0; n < 6000 && digit_drive[d] === 1'b1; n++) begin
      @(posedge clk);
      #1;
      len++;
    end
  endtask
  // Starts the sequencer and checks start plane, step order and spacing.
  task automatic auto_run(input logic [7:0] s, input int gap, input bit two = 1'b0);
    int k;
    int t;
    logic [1:0] prev;
    wr(ADDR_PLANE, s);
    check("plane_auto_start", 16'h0000, {14'h0, displayed_plane});
    prev = 2'b00;
    for (k = 0; k < 5; k++) begin
      t = 0;
      while (displayed_plane === prev && t < 300) begin
        @(posedge clk);
        #1;
        t++;
      end
      if (k > 0 || gap == 0) check("plane_gap", 16'((gap == 0) ? 300 : gap), 16'(t));
      if (gap == 0) break;
      check("plane_next", {14'h0, two ? {1'b0, ~prev[0]} : 2'(prev + 2'b01)}, {14'h0, displayed_plane});
      prev = displayed_plane;
    end
  endtask
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // Register write and read back, with the high pointer bits and an unmapped code.
  task automatic test_regs();
    logic [6:0] a [6] = '{ADDR_PANEL, ADDR_DRIVER, ADDR_PTR_LO, ADDR_PTR_HI, ADDR_GRAD, 7'h0E};
    logic [7:0] w [6] = '{8'h5A, 8'hC3, 8'h3C, 8'hFF, 8'hFF, 8'h77};
    logic [7:0] e [6] = '{8'h5A, 8'hC3, 8'h3C, 8'h3F, 8'h03, 8'h00};
    logic [7:0] d;
    int i;
    for (i = 0; i < 6; i++) begin
      wr(a[i], w[i]);
      rd(a[i], d);
      check("reg_readback", {8'h00, e[i]}, {8'h00, d});
    end
    check("driver_select", 16'h00C3, {8'h00, driver_select});
  endtask
  // Byte writes at the top of display memory wrap the pointer to zero.
  task automatic test_ptr();
    logic [15:0] r;
    logic [7:0] d;
    int base;
    base = wr_count;
    wr(ADDR_PTR_LO, 8'hFF);
    wr(ADDR_PTR_HI, 8'h3F);
    host_u.xfer(8, 16'h00A5, r);
    check("mem_addr_top", 16'h3FFF, {2'b00, wr_addr});
    check("mem_data", 16'h00A5, {8'h00, wr_data});
    host_u.xfer(8, 16'h005A, r);
    check("mem_addr_wrap", 16'h0000, {2'b00, wr_addr});
    check("mem_write_count", 16'h0002, 16'(wr_count - base));
    rd(ADDR_PTR_LO, d);
    check("ptr_after_wrap", 16'h0001, {8'h00, d});
  endtask
  // Manual selection and automatic sequencing in both plane depths.
  task automatic test_planes();
    logic [7:0] d;
    wr(ADDR_PLANE, 8'h02);
    check("plane_manual", 16'h0002, {14'h0, displayed_plane});
    auto_run(8'h41, 64);
    auto_run(8'h42, 128);
    auto_run(8'hC4, 16);
    auto_run(8'h40, 0);
    wr(ADDR_CONFIG, 8'h80);
    check("depth_bit", 16'h0001, {15'h0, plane_depth_select});
    check("depth_locked", 16'h0000, {15'h0, lite_depth});
    wr(ADDR_PLANE, 8'h03);
    check("plane_two_hi", 16'h0001, {14'h0, displayed_plane});
    rd(ADDR_CONFIG, d);
    check("config_read", 16'h0084, {8'h00, d});
    wr(ADDR_PLANE, 8'h02);
    check("plane_two_lo", 16'h0000, {14'h0, displayed_plane});
    auto_run(8'hC4, 16, 1'b1);
  endtask
  // Digit windows scale with panel and digit codes.
  task automatic test_pwm();
    int len;
    int lit1;
    wr(ADDR_PANEL, 8'hFF);
    wr(ADDR_DIGIT0, 8'h80);
    wr(ADDR_DIGIT1, 8'hFF);
    measure(0, len);
    check("digit0_on", 16'(127 * STEP_CYCLES), 16'(len));
    measure(1, len);
    check("digit1_on", 16'(254 * STEP_CYCLES), 16'(len));
    // Full level on digit 0 and off on digit 1, counted over one whole multiplex cycle.
    @(posedge clk);
    #1 pixel_level = 4'h3;
    len = 0;
    lit1 = 0;
    repeat (2 * PWM_STEPS * STEP_CYCLES) begin
      @(posedge clk);
      #1;
      if (pixel_lit[0] === 1'b1) len++;
      if (pixel_lit[1] !== 1'b0) lit1++;
    end
    check("lit_full", 16'(127 * STEP_CYCLES), 16'(len));
    check("lit_off", 16'h0000, 16'(lit1));
    wr(ADDR_PANEL, 8'h01);
    wr(ADDR_DIGIT0, 8'hFF);
    measure(0, len);
    check("panel_min", 16'(STEP_CYCLES), 16'(len));
    wr(ADDR_PANEL, 8'h00);
    measure(0, len);
    check("panel_off", 16'h0000, 16'(len));
  endtask
  // Main sequence: reset for 12 cycles, then each scenario in turn.
  initial begin
    rst_n = 1'b0;
    pixel_level = 4'h5;
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (6) @(posedge clk);
    check("driver_reset", {8'h00, RST_BYTE}, {8'h00, driver_select});
    test_regs();
    test_ptr();
    test_planes();
    test_pwm();
    test_done();
  end
endmodule // led_matrix_intensity_plane_ctrl_tb_top
`default_nettype wire
